// [design/pbs_map.svh]
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH
// ==========================================
// register offsets
`define PBS_REG_ID_HI 16'h0002
`define PBS_REG_ID_LO 16'h0003
`define PBS_REG_CTL 16'h0010
`define PBS_REG_STAT 16'h0011
`define PBS_REG_ADV 16'h0012
`define PBS_REG_ABIL 16'h0013
`define PBS_C45_DEVAD 5'h1F
// ==========================================
// field positions
`define PBS_CTL_PD 0
`define PBS_CTL_AN_EN 12
`define PBS_CTL_SRST 15
`define PBS_STAT_RDY 0
`define PBS_STAT_PD 1
`define PBS_ADV_ABL 0
`define PBS_ADV_REQ 1
`define PBS_ADV_MST 2
`define PBS_ADV_FORCED_MASTER_CFG 3
`define PBS_ABIL_CAP 0
`define PBS_ABIL_IF_LSB 1
`define PBS_ABIL_CONV 3
// ==========================================
// interface codes
`define PBS_IF_RMII 2'h0
`define PBS_IF_RGMII 2'h1
`define PBS_IF_RSVD 2'h2
`define PBS_IF_MII 2'h3
// ==========================================
// timing
`define PBS_CLK_NS 40
`define PBS_STARTUP_NS 10000
`define PBS_STARTUP_CYC ((`PBS_STARTUP_NS + `PBS_CLK_NS - 1) / `PBS_CLK_NS)
`define PBS_SETTLE_CYC 3
`define PBS_PREAMBLE 32
`endif

// [design/pbs_pkg.sv]
package pbs_pkg;
    typedef enum logic [1:0] {BOOT_SETTLE, BOOT_START, BOOT_PD, BOOT_RUN}
        pbs_boot_e;
    typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} pbs_mdio_e;
    typedef struct packed {
        logic pd;
        logic role;
        logic low_only;
        logic if_hi;
        logic if_lo;
        logic conv;
    } pbs_strap_s;
    typedef struct packed {
        logic wr;
        logic c45;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pbs_req_s;
    typedef struct packed {
        logic pd;
        logic rdy;
        logic an_en;
        logic an_start;
        logic adv_abl;
        logic adv_req;
        logic adv_mst;
        logic forced_master_cfg;
        logic [1:0] host_if;
        logic conv;
        logic lvl_hi;
    } pbs_out_s;
endpackage

// [design/pbs_mdio_slave.sv]
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_mdio_slave #(
    parameter logic [4:0] PHY_ADDR = 5'h00
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic [15:0] rdata_i,
    output pbs_pkg::pbs_req_s req_o,
    output logic req_valid_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    logic mdc_s1_ff, mdc_s2_ff, mdc_s3_ff, dio_s1_ff, dio_s2_ff;
    pbs_pkg::pbs_mdio_e st_ff, nxt_st;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [5:0] ones_ff, nxt_ones;
    logic [15:0] sr_ff, nxt_sr, a45_ff, nxt_a45;
    logic [1:0] op_ff, nxt_op;
    logic go_ff, nxt_go, rd_ff, nxt_rd, vld_ff, nxt_vld;
    logic o_ff, nxt_o, oe_ff, nxt_oe;
    pbs_pkg::pbs_req_s req_ff, nxt_req;
    logic edge_w, bit_w;
    logic [12:0] hdr_w;
    assign edge_w = mdc_s2_ff & ~mdc_s3_ff;
    assign bit_w = dio_s2_ff;
    assign hdr_w = {sr_ff[11:0], bit_w};
    // ==========================================
    // frame decode
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_ones = ones_ff;
        nxt_sr = sr_ff;
        nxt_a45 = a45_ff;
        nxt_op = op_ff;
        nxt_go = go_ff;
        nxt_rd = rd_ff;
        nxt_o = o_ff;
        nxt_oe = oe_ff;
        nxt_req = req_ff;
        nxt_vld = 1'b0;
        if (edge_w) begin
            unique case (st_ff)
                pbs_pkg::MD_PRE: begin
                    nxt_ones = 6'h00;
                    if (bit_w && ones_ff != 6'(`PBS_PREAMBLE))
                        nxt_ones = ones_ff + 6'h01;
                    else if (bit_w)
                        nxt_ones = ones_ff;
                    else if (ones_ff == 6'(`PBS_PREAMBLE)) begin
                        nxt_st = pbs_pkg::MD_HDR;
                        nxt_cnt = 5'h0C;
                    end
                end
                pbs_pkg::MD_HDR: begin
                    nxt_sr = {sr_ff[14:0], bit_w};
                    nxt_cnt = cnt_ff - 5'h01;
                    if (cnt_ff == 5'h00) begin
                        nxt_op = hdr_w[11:10];
                        nxt_req.c45 = ~hdr_w[12];
                        nxt_req.dev = hdr_w[4:0];
                        nxt_req.addr = hdr_w[12] ? {11'h000, hdr_w[4:0]}
                            : a45_ff;
                        nxt_go = hdr_w[9:5] == PHY_ADDR && (hdr_w[12]
                            || hdr_w[4:0] == `PBS_C45_DEVAD); // [RULE_08]
                        nxt_rd = hdr_w[12] ? hdr_w[11:10] == 2'h2
                            : hdr_w[11];
                        nxt_st = pbs_pkg::MD_TA;
                        nxt_cnt = 5'h01;
                    end
                end
                pbs_pkg::MD_TA: begin
                    nxt_cnt = cnt_ff - 5'h01;
                    if (go_ff && rd_ff) begin
                        nxt_oe = 1'b1;
                        nxt_o = cnt_ff == 5'h00 ? rdata_i[15] : 1'b0;
                        nxt_sr = {rdata_i[14:0], 1'b0};
                    end
                    if (cnt_ff == 5'h00) begin
                        nxt_st = pbs_pkg::MD_DATA;
                        nxt_cnt = 5'h0F;
                    end
                end
                pbs_pkg::MD_DATA: begin
                    nxt_cnt = cnt_ff - 5'h01;
                    nxt_o = sr_ff[15];
                    nxt_sr = rd_ff ? {sr_ff[14:0], 1'b0}
                        : {sr_ff[14:0], bit_w};
                    if (cnt_ff == 5'h00) begin
                        nxt_oe = 1'b0;
                        nxt_st = pbs_pkg::MD_PRE;
                        nxt_ones = 6'h00;
                        if (go_ff && req_ff.c45 && op_ff == 2'h0)
                            nxt_a45 = {sr_ff[14:0], bit_w};
                        else if (go_ff && !rd_ff) begin
                            nxt_vld = 1'b1;
                            nxt_req.wr = 1'b1;
                            nxt_req.wdata = {sr_ff[14:0], bit_w};
                        end
                        if (go_ff && req_ff.c45 && op_ff == 2'h2)
                            nxt_a45 = a45_ff + 16'h0001;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {mdc_s1_ff, mdc_s2_ff, mdc_s3_ff} <= 3'h0;
            {dio_s1_ff, dio_s2_ff} <= 2'h3;
            st_ff <= pbs_pkg::MD_PRE;
            cnt_ff <= 5'h00;
            ones_ff <= 6'h00;
            sr_ff <= 16'h0000;
            a45_ff <= 16'h0000;
            op_ff <= 2'h0;
            {go_ff, rd_ff, vld_ff, o_ff, oe_ff} <= 5'h00;
            req_ff <= '0;
        end else begin
            mdc_s1_ff <= mdc_i;
            mdc_s2_ff <= mdc_s1_ff;
            mdc_s3_ff <= mdc_s2_ff;
            dio_s1_ff <= mdio_i;
            dio_s2_ff <= dio_s1_ff;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ones_ff <= nxt_ones;
            sr_ff <= nxt_sr;
            a45_ff <= nxt_a45;
            op_ff <= nxt_op;
            {go_ff, rd_ff, vld_ff} <= {nxt_go, nxt_rd, nxt_vld};
            {o_ff, oe_ff} <= {nxt_o, nxt_oe};
            req_ff <= nxt_req;
        end
    end
    assign req_o = req_ff;
    assign req_valid_o = vld_ff;
    assign mdio_o = o_ff;
    assign mdio_oe_o = oe_ff;
    chk_oe_window: assert property ( // [RULE_08]
        @(posedge clk_i) disable iff (rst_i)
        oe_ff |-> (st_ff == pbs_pkg::MD_TA || st_ff == pbs_pkg::MD_DATA))
        else $error("mdio driven outside turnaround or data");
endmodule

// [design/pbs_strap_cfg.sv]
`timescale 1ns/1ps
`include "pbs_map.svh"
// Functional notes
// (RULE_01) strap powerdown holds until software clears
// (RULE_02) unmanaged board holds powerdown strap high
// (RULE_03) role strap picks advertised role preference
// (RULE_04) floating level strap enables both levels
// (RULE_05) interface straps select host interface type
// (RULE_06) converter strap works only with RMII
// (RULE_07) autonegotiation starts only after leaving powerdown
// (RULE_08) identifier at 0x2/0x3, both frame types
// (RULE_09) identifier nonzero only after start-up completes
// (RULE_10) identifier words carry oui, model, revision
// (RULE_11) ready flag set when start-up done
// (RULE_12) powerdown status shows current powerdown state
// (RULE_13) autonegotiation enabled out of every reset
// (RULE_14) read-only capability bit from inverted level strap
// (RULE_15) advertise-high only accepted when capable
// (RULE_16) request bit advertises high or low preference
// (RULE_17) advertise-high clear forces low level result
// (RULE_18) powerdown control reloads from strap each reset
// (RULE_19) role strap defaults advertised and forced master
// (RULE_20) strap codes 00 RMII 01 RGMII 11 MII
// (RULE_21) level strap high blocks high-level writes
// (RULE_22) straps captured once at reset release
module pbs_strap_cfg #(
    parameter logic [15:0] ID_OUI_HI = 16'h1A2B, // arbitrary value
    parameter logic [5:0] ID_OUI_LO = 6'h15, // arbitrary value
    parameter logic [5:0] ID_MODEL = 6'h0C, // arbitrary value
    parameter logic [3:0] ID_REV = 4'h3, // arbitrary value
    parameter logic [4:0] PHY_ADDR = 5'h00
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic powerdown_strap_i,
    input wire logic role_pref_strap_i,
    input wire logic low_level_only_strap_i,
    input wire logic host_if_strap_lo_i,
    input wire logic host_if_strap_hi_i,
    input wire logic converter_strap_i,
    input wire logic an_done_i,
    input wire logic lp_high_level_ability_i,
    input wire logic lp_high_level_request_i,
    output logic soft_powerdown_state_o,
    output logic system_ready_flag_o,
    output logic an_enable_o,
    output logic an_start_o,
    output logic adv_high_level_ability_o,
    output logic adv_high_level_request_o,
    output logic adv_master_pref_o,
    output logic forced_master_cfg_o,
    output logic [1:0] host_if_sel_o,
    output logic converter_en_o,
    output logic tx_level_high_o
);
    // ==========================================
    // declarations
    pbs_pkg::pbs_strap_s pin_w, s1_ff, s2_ff, cap_ff, nxt_cap;
    pbs_pkg::pbs_boot_e boot_ff, nxt_boot;
    pbs_pkg::pbs_req_s req_w;
    pbs_pkg::pbs_out_s out_ff, nxt_out;
    logic [8:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic pd_ctl_ff, nxt_pd_ctl;
    logic an_en_ff, nxt_an_en;
    logic cap_hi_ff, nxt_cap_hi;
    logic abl_ff, nxt_abl, req_hi_ff, nxt_req_hi;
    logic mst_ff, nxt_mst, forced_master_cfg_ff, nxt_forced_master_cfg;
    logic req_vld_w, capture_w, srst_w;
    logic [15:0] rdata_w;

    // ==========================================
    // register address decode
    function automatic logic reg_hit(input pbs_pkg::pbs_req_s r,
                                     input logic [15:0] a);
        reg_hit = (!r.c45 || r.dev == `PBS_C45_DEVAD) && r.addr == a;
    endfunction

    // ==========================================
    // management frame engine
    pbs_mdio_slave #(
        .PHY_ADDR(PHY_ADDR)
    ) u_mdio (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .rdata_i(rdata_w),
        .req_o(req_w),
        .req_valid_o(req_vld_w),
        .mdio_o(mdio_o),
        .mdio_oe_o(mdio_oe_o)
    );

    // ==========================================
    // strap pin synchroniser
    assign pin_w = '{pd: powerdown_strap_i, role: role_pref_strap_i,
                     low_only: low_level_only_strap_i,
                     if_hi: host_if_strap_hi_i,
                     if_lo: host_if_strap_lo_i,
                     conv: converter_strap_i};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= pin_w;
            s2_ff <= s1_ff;
        end
    end

    // ==========================================
    // register read mux
    always_comb begin
        rdata_w = 16'h0000;
        if (rdy_ff) begin
            if (reg_hit(req_w, `PBS_REG_ID_HI))
                rdata_w = ID_OUI_HI; // [RULE_08] [RULE_10]
            else if (reg_hit(req_w, `PBS_REG_ID_LO))
                rdata_w = {ID_OUI_LO, ID_MODEL, ID_REV}; // [RULE_10]
            else if (reg_hit(req_w, `PBS_REG_CTL)) begin
                rdata_w[`PBS_CTL_PD] = pd_ctl_ff;
                rdata_w[`PBS_CTL_AN_EN] = an_en_ff;
            end else if (reg_hit(req_w, `PBS_REG_ADV)) begin
                rdata_w[`PBS_ADV_ABL] = abl_ff;
                rdata_w[`PBS_ADV_REQ] = req_hi_ff;
                rdata_w[`PBS_ADV_MST] = mst_ff;
                rdata_w[`PBS_ADV_FORCED_MASTER_CFG] = forced_master_cfg_ff;
            end else if (reg_hit(req_w, `PBS_REG_ABIL)) begin
                rdata_w[`PBS_ABIL_CAP] = cap_hi_ff; // [RULE_14]
                rdata_w[`PBS_ABIL_IF_LSB +: 2] = {cap_ff.if_hi,
                                                  cap_ff.if_lo};
                rdata_w[`PBS_ABIL_CONV] = out_ff.conv;
            end
        end
        if (reg_hit(req_w, `PBS_REG_STAT)) begin
            rdata_w[`PBS_STAT_RDY] = rdy_ff; // [RULE_11]
            rdata_w[`PBS_STAT_PD] = boot_ff == pbs_pkg::BOOT_PD; // [RULE_12]
        end
    end

    // ==========================================
    // soft reset write decode and strap capture strobe
    assign srst_w = req_vld_w && rdy_ff && reg_hit(req_w, `PBS_REG_CTL)
        && req_w.wdata[`PBS_CTL_SRST];
    assign capture_w = boot_ff == pbs_pkg::BOOT_SETTLE
        && cnt_ff == 9'(`PBS_SETTLE_CYC - 1);

    // ==========================================
    // start-up sequencer and control bits
    always_comb begin
        nxt_boot = boot_ff;
        nxt_cnt = cnt_ff;
        nxt_rdy = rdy_ff;
        nxt_cap = cap_ff;
        nxt_pd_ctl = pd_ctl_ff;
        nxt_an_en = an_en_ff;
        nxt_cap_hi = cap_hi_ff;
        nxt_abl = abl_ff;
        nxt_req_hi = req_hi_ff;
        nxt_mst = mst_ff;
        nxt_forced_master_cfg = forced_master_cfg_ff;
        if (req_vld_w && rdy_ff && !srst_w) begin
            if (reg_hit(req_w, `PBS_REG_CTL)) begin
                nxt_pd_ctl = req_w.wdata[`PBS_CTL_PD]; // [RULE_18]
                nxt_an_en = req_w.wdata[`PBS_CTL_AN_EN];
            end
            if (reg_hit(req_w, `PBS_REG_ADV)) begin
                nxt_abl = req_w.wdata[`PBS_ADV_ABL]
                    & cap_hi_ff; // [RULE_15] [RULE_21]
                nxt_req_hi = req_w.wdata[`PBS_ADV_REQ] & cap_hi_ff;
                nxt_mst = req_w.wdata[`PBS_ADV_MST];
                nxt_forced_master_cfg = req_w.wdata[`PBS_ADV_FORCED_MASTER_CFG];
            end
        end
        unique case (boot_ff)
            pbs_pkg::BOOT_SETTLE: begin
                nxt_cnt = cnt_ff + 9'h001;
                if (capture_w) begin
                    nxt_cap = s2_ff; // [RULE_22]
                    nxt_pd_ctl = ~s2_ff.pd; // [RULE_01] [RULE_18]
                    nxt_mst = s2_ff.role; // [RULE_03] [RULE_19]
                    nxt_forced_master_cfg = s2_ff.role; // [RULE_19]
                    nxt_cap_hi = ~s2_ff.low_only; // [RULE_04] [RULE_14]
                    nxt_abl = ~s2_ff.low_only; // [RULE_04]
                    nxt_req_hi = 1'b0;
                    nxt_an_en = 1'b1; // [RULE_13]
                    nxt_boot = pbs_pkg::BOOT_START;
                    nxt_cnt = 9'h000;
                end
            end
            pbs_pkg::BOOT_START: begin
                nxt_cnt = cnt_ff + 9'h001;
                if (cnt_ff == 9'(`PBS_STARTUP_CYC - 1)) begin
                    nxt_rdy = 1'b1; // [RULE_09] [RULE_11]
                    nxt_boot = pd_ctl_ff ? pbs_pkg::BOOT_PD
                        : pbs_pkg::BOOT_RUN;
                end
            end
            pbs_pkg::BOOT_PD: begin
                if (!pd_ctl_ff)
                    nxt_boot = pbs_pkg::BOOT_RUN; // [RULE_01] [RULE_07]
            end
            pbs_pkg::BOOT_RUN: begin
                if (pd_ctl_ff)
                    nxt_boot = pbs_pkg::BOOT_PD;
            end
        endcase
        if (srst_w) begin
            nxt_boot = pbs_pkg::BOOT_SETTLE; // [RULE_18] [RULE_22]
            nxt_cnt = 9'h000;
            nxt_rdy = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_ff <= pbs_pkg::BOOT_SETTLE;
            cnt_ff <= 9'h000;
            rdy_ff <= 1'b0;
            cap_ff <= '0;
            pd_ctl_ff <= 1'b1;
            an_en_ff <= 1'b1;
            cap_hi_ff <= 1'b0;
            abl_ff <= 1'b0;
            req_hi_ff <= 1'b0;
            mst_ff <= 1'b0;
            forced_master_cfg_ff <= 1'b0;
        end else begin
            boot_ff <= nxt_boot;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
            cap_ff <= nxt_cap;
            pd_ctl_ff <= nxt_pd_ctl;
            an_en_ff <= nxt_an_en;
            cap_hi_ff <= nxt_cap_hi;
            abl_ff <= nxt_abl;
            req_hi_ff <= nxt_req_hi;
            mst_ff <= nxt_mst;
            forced_master_cfg_ff <= nxt_forced_master_cfg;
        end
    end

    // ==========================================
    // output stage
    always_comb begin
        nxt_out = '0;
        nxt_out.pd = boot_ff == pbs_pkg::BOOT_PD; // [RULE_12]
        nxt_out.rdy = rdy_ff;
        nxt_out.an_en = boot_ff == pbs_pkg::BOOT_RUN
            && an_en_ff; // [RULE_07]
        nxt_out.an_start = nxt_out.an_en && !out_ff.an_en; // [RULE_07]
        nxt_out.adv_abl = abl_ff;
        nxt_out.adv_req = req_hi_ff; // [RULE_16]
        nxt_out.adv_mst = mst_ff; // [RULE_03]
        nxt_out.forced_master_cfg = forced_master_cfg_ff;
        nxt_out.host_if = {cap_ff.if_hi, cap_ff.if_lo}; // [RULE_05] [RULE_20]
        nxt_out.conv = cap_ff.conv && {cap_ff.if_hi, cap_ff.if_lo}
            == `PBS_IF_RMII; // [RULE_06]
        nxt_out.lvl_hi = an_done_i && abl_ff && lp_high_level_ability_i
            && (req_hi_ff || lp_high_level_request_i); // [RULE_16] [RULE_17]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            out_ff <= '0;
        else
            out_ff <= nxt_out;
    end

    assign soft_powerdown_state_o = out_ff.pd;
    assign system_ready_flag_o = out_ff.rdy;
    assign an_enable_o = out_ff.an_en;
    assign an_start_o = out_ff.an_start;
    assign adv_high_level_ability_o = out_ff.adv_abl;
    assign adv_high_level_request_o = out_ff.adv_req;
    assign adv_master_pref_o = out_ff.adv_mst;
    assign forced_master_cfg_o = out_ff.forced_master_cfg;
    assign host_if_sel_o = out_ff.host_if;
    assign converter_en_o = out_ff.conv;
    assign tx_level_high_o = out_ff.lvl_hi;

    // ==========================================
    // checks
    chk_pd_hold_off: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        (boot_ff == pbs_pkg::BOOT_PD && pd_ctl_ff && !srst_w)
        |=> boot_ff == pbs_pkg::BOOT_PD ##1 !an_enable_o)
        else $error("powerdown left while control still set");
    chk_an_after_wake: assert property ( // [RULE_07]
        @(posedge clk_i) disable iff (rst_i)
        (boot_ff == pbs_pkg::BOOT_PD && !pd_ctl_ff && an_en_ff)
        |=> ##1 an_start_o && an_enable_o)
        else $error("autonegotiation not started after wake");
    chk_role_default: assert property ( // [RULE_19]
        @(posedge clk_i) disable iff (rst_i)
        capture_w |=> mst_ff == cap_ff.role
        && forced_master_cfg_ff == cap_ff.role && an_en_ff)
        else $error("role or autoneg defaults not loaded");
    chk_pd_default: assert property ( // [RULE_18]
        @(posedge clk_i) disable iff (rst_i)
        capture_w |=> pd_ctl_ff == ~cap_ff.pd)
        else $error("powerdown control not loaded from strap");
    chk_abl_gate: assert property ( // [RULE_15]
        @(posedge clk_i) disable iff (rst_i)
        !cap_hi_ff |-> !abl_ff && !req_hi_ff)
        else $error("high level advertised without ability");
    chk_cap_strap: assert property ( // [RULE_14]
        @(posedge clk_i) disable iff (rst_i)
        capture_w |=> cap_hi_ff == !cap_ff.low_only)
        else $error("ability bit not inverse of level strap");
    chk_id_early: assert property ( // [RULE_09]
        @(posedge clk_i) disable iff (rst_i)
        (!rdy_ff && !reg_hit(req_w, `PBS_REG_STAT)) |-> rdata_w == 16'h0000)
        else $error("register contents visible before start-up");
    chk_ready_time: assert property ( // [RULE_11]
        @(posedge clk_i) disable iff (rst_i)
        $rose(boot_ff == pbs_pkg::BOOT_START)
        |-> !rdy_ff [*8])
        else $error("ready flag set during start-up");
    chk_conv_rmii: assert property ( // [RULE_06]
        @(posedge clk_i) disable iff (rst_i)
        converter_en_o |-> host_if_sel_o == `PBS_IF_RMII)
        else $error("converter enabled outside RMII");
    chk_level_low: assert property ( // [RULE_17]
        @(posedge clk_i) disable iff (rst_i)
        !adv_high_level_ability_o |-> !tx_level_high_o)
        else $error("high level resolved without ability");
    chk_strap_hold: assert property ( // [RULE_22]
        @(posedge clk_i) disable iff (rst_i)
        (boot_ff != pbs_pkg::BOOT_SETTLE) |=> $stable(cap_ff)
        || $past(srst_w))
        else $error("captured straps changed outside reset");
    chk_start_pulse: assert property ( // [RULE_07]
        @(posedge clk_i) disable iff (rst_i)
        an_start_o |-> an_enable_o && !$past(an_enable_o))
        else $error("autonegotiation start without rising enable");
    chk_an_not_pd: assert property ( // [RULE_07]
        @(posedge clk_i) disable iff (rst_i)
        an_enable_o |-> !soft_powerdown_state_o)
        else $error("autonegotiation enabled in powerdown");
endmodule

// [sim/pbs_host_model.sv]
`timescale 1ns/1ps
// ==========================================
// management host: bit-banged frames, clock idle low
module pbs_host_model (
    input wire logic clk_i,
    input wire logic md_i,
    output logic mdc_o,
    output logic md_o,
    output logic md_oe_o
);
    initial begin
        mdc_o = 1'b0;
        md_o = 1'b1;
        md_oe_o = 1'b0;
    end
    task automatic tick(input logic drv, input logic b, output logic s);
        md_oe_o = drv;
        md_o = b;
        repeat (8) @(negedge clk_i);
        s = md_i;
        mdc_o = 1'b1;
        repeat (8) @(negedge clk_i);
        mdc_o = 1'b0;
    endtask
    // host releases the line over turnaround and data of a read
    task automatic frame(input logic [1:0] st, input logic [1:0] op,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] hdr;
        logic rdop;
        logic s;
        hdr = {st, op, 5'h00, ra, 2'b10, wd};
        rdop = (st == 2'b01) ? (op == 2'b10) : op[1];
        rd = 16'h0000;
        @(negedge clk_i);
        for (int i = 0; i < 32; i++) begin
            tick(1'b1, 1'b1, s);
        end
        for (int i = 31; i >= 0; i--) begin
            tick(!(rdop && i < 18), hdr[i], s);
            if (i < 16) begin
                rd[i] = s;
            end
        end
        md_oe_o = 1'b0;
    endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
// ==========================================
// bench for strap configuration block
module testbench;
    localparam logic [15:0] IDH = 16'h5A3C; // arbitrary value
    localparam logic [15:0] IDL = {6'h2D, 6'h11, 4'h6};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pbs_pkg::pbs_strap_s sp = '0;
    logic an_done = 1'b0;
    logic lp_abl = 1'b0;
    logic lp_req = 1'b0;
    logic mdc, h_o, h_oe, d_o, d_oe, an_seen;
    logic pd, rdy, an_en, an_st, abl, req, mst, cfg, conv, lvl;
    logic [1:0] hif;
    logic [15:0] rd;
    wire mdio = d_oe ? d_o : (h_oe ? h_o : 1'b1);
    int err_total = 0;
    int num_checks = 0;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        an_seen <= rst_i ? 1'b0 : (an_seen | an_st);
    end
    pbs_host_model host (.clk_i(clk_i), .md_i(mdio), .mdc_o(mdc),
        .md_o(h_o), .md_oe_o(h_oe));
    pbs_strap_cfg #(.ID_OUI_HI(IDH), .ID_OUI_LO(6'h2D), .ID_MODEL(6'h11),
        .ID_REV(4'h6)) dut (.clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc),
        .mdio_i(mdio), .mdio_o(d_o), .mdio_oe_o(d_oe),
        .powerdown_strap_i(sp.pd), .role_pref_strap_i(sp.role),
        .low_level_only_strap_i(sp.low_only), .host_if_strap_lo_i(sp.if_lo),
        .host_if_strap_hi_i(sp.if_hi), .converter_strap_i(sp.conv),
        .an_done_i(an_done), .lp_high_level_ability_i(lp_abl),
        .lp_high_level_request_i(lp_req), .soft_powerdown_state_o(pd),
        .system_ready_flag_o(rdy), .an_enable_o(an_en), .an_start_o(an_st),
        .adv_high_level_ability_o(abl), .adv_high_level_request_o(req),
        .adv_master_pref_o(mst), .forced_master_cfg_o(cfg),
        .host_if_sel_o(hif), .converter_en_o(conv), .tx_level_high_o(lvl));
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 400) begin
            n++;
            @(negedge clk_i);
        end
        if (rdy !== 1'b1) begin
            err_total++;
            results();
        end
        repeat (2) @(negedge clk_i);
        sp = ~sp;
    endtask
    task automatic boot(input pbs_pkg::pbs_strap_s s);
        sp = s;
        rst_i = 1'b1;
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (100) @(negedge clk_i);
        chk("ready early", 16'h0, {15'h0, rdy});
        wait_rdy();
    endtask
    task automatic wr(input logic [4:0] r, input logic [15:0] w);
        host.frame(2'b01, 2'b01, r, w, rd);
        repeat (4) @(negedge clk_i);
    endtask
    task automatic rd22(input logic [4:0] r);
        host.frame(2'b01, 2'b10, r, 16'h0, rd);
    endtask
    initial begin
        @(negedge clk_i);
        boot(6'b010011);
        rd22(5'h02);
        chk("id high", IDH, rd);
        rd22(5'h03);
        chk("id low", IDL, rd);
        host.frame(2'b00, 2'b00, 5'h1F, 16'h0002, rd);
        host.frame(2'b00, 2'b10, 5'h1F, 16'h0, rd);
        chk("id c45 inc", IDH, rd);
        host.frame(2'b00, 2'b11, 5'h1F, 16'h0, rd);
        chk("id c45", IDL, rd);
        rd22(5'h11);
        chk("status", 16'h3, rd);
        chk("pd held", 16'h1, {15'h0, pd});
        chk("an held", 16'h0, {14'h0, an_en, an_seen});
        chk("role", 16'h3, {14'h0, mst, cfg});
        chk("if", 16'h2, {13'h0, hif, conv});
        chk("able", 16'h1, {15'h0, abl});
        an_done = 1'b1;
        lp_abl = 1'b1;
        wr(5'h10, 16'h1000);
        chk("pd exit", 16'h1, {14'h0, pd, an_seen});
        wr(5'h12, 16'h0003);
        chk("lvl req", 16'h7, {13'h0, abl, req, lvl});
        wr(5'h12, 16'h0001);
        chk("lvl pref", 16'h0, {15'h0, lvl});
        lp_req = 1'b1;
        wr(5'h12, 16'h0002);
        chk("lvl low", 16'h0, {15'h0, lvl});
        wr(5'h10, 16'h0000);
        chk("an off", 16'h0, {15'h0, an_en});
        boot(6'b101001);
        chk("run", 16'h1, {14'h0, pd, an_en});
        chk("role", 16'h0, {14'h0, mst, cfg});
        chk("rmii", 16'h1, {13'h0, hif, conv});
        wr(5'h12, 16'h0003);
        rd22(5'h12);
        chk("adv blocked", 16'h0, {rd[15:2], abl, req});
        rd22(5'h13);
        chk("abil", 16'h8, rd);
        host.frame(2'b01, 2'b01, 5'h10, 16'h8000, rd);
        chk("sreset", 16'h0, {15'h0, rdy});
        wait_rdy();
        chk("sreset pd", 16'h1, {15'h0, pd});
        for (int c = 0; c < 4; c++) begin
            boot({3'b100, c[1:0], 1'b1});
            chk("if code", {14'h0, c[1:0]}, {14'h0, hif});
            chk("conv", {15'h0, c == 0}, {15'h0, conv});
        end
        results();
    end
endmodule
